/* File: hdl/cmpc_pkg.sv */
// package: register map, field positions and codes for the comparator control block
// assumes: 32-bit axi4-lite slave, one aligned word per register
`default_nettype none
package cmpc_pkg;
    // printed offsets are not all multiples of four: they are indices, byte address is index * 4
    localparam logic [2:0] CMPC_IDX_CONTROL = 3'h0;
    localparam logic [2:0] CMPC_IDX_INPUT_SELECT = 3'h2;
    localparam logic [2:0] CMPC_IDX_IRQ_ENABLE = 3'h6;
    localparam logic [2:0] CMPC_IDX_STATUS = 3'h7;
    localparam int CMPC_ADDR_LSB = 2;
    localparam int CMPC_IDX_W = 3;
    localparam logic [7:0] CMPC_CONTROL_RST = 8'h00;
    localparam logic [7:0] CMPC_INPUT_SELECT_RST = 8'h00;
    localparam logic [7:0] CMPC_IRQ_ENABLE_RST = 8'h00;
    // control register fields
    localparam int CMPC_BIT_ENABLE = 0;
    localparam int CMPC_HYS_LO = 1;
    localparam int CMPC_HYS_HI = 2;
    localparam int CMPC_EDGE_LO = 4;
    localparam int CMPC_EDGE_HI = 5;
    localparam int CMPC_BIT_OUTPUT_PAD_ENABLE = 6;
    localparam int CMPC_BIT_RUN_IN_STANDBY = 7;
    // input select fields
    localparam int CMPC_NEG_LO = 0;
    localparam int CMPC_NEG_HI = 1;
    localparam int CMPC_BIT_POS = 3;
    localparam int CMPC_BIT_INVERT = 7;
    // irq enable and status fields
    localparam int CMPC_BIT_IRQ = 0;
    localparam int CMPC_BIT_STATE = 4;
    // edge select codes
    localparam logic [1:0] CMPC_ANY_EDGE_CODE = 2'h0;
    localparam logic [1:0] CMPC_FALL_EDGE_CODE = 2'h2;
    localparam logic [1:0] CMPC_RISE_EDGE_CODE = 2'h3;
    // hysteresis codes
    localparam logic [1:0] CMPC_HYS_OFF = 2'h0;
    localparam logic [1:0] CMPC_HYS_10MV = 2'h1;
    localparam logic [1:0] CMPC_HYS_25MV = 2'h2;
    localparam logic [1:0] CMPC_HYS_50MV = 2'h3;
    // input select codes and axi response codes
    localparam logic [1:0] CMPC_NEG_PIN_ZERO = 2'h0;
    localparam logic [1:0] CMPC_NEG_VREF = 2'h2;
    localparam logic CMPC_POS_PIN_ZERO = 1'b0;
    localparam logic [1:0] CMPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CMPC_RESP_SLVERR = 2'h2;
    // sleep modes seen by the block
    typedef enum logic [1:0] {
        CMPC_SLEEP_ACTIVE,
        CMPC_SLEEP_IDLE,
        CMPC_SLEEP_STANDBY,
        CMPC_SLEEP_POWER_DOWN
    } cmpc_sleep_t;
endpackage : cmpc_pkg
`default_nettype wire

/* File: hdl/cmpc_top.sv */
// comparator control and status logic behind an axi4-lite register slave
// assumes: analog core outside; its raw output is asynchronous to aclk; sleep state from the power manager
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`default_nettype none
module cmpc_top
    import cmpc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cmpc_sleep_t sleep_mode,
    input wire logic comparator_raw,
    output logic comparator_enable,
    output logic [1:0] hysteresis_select,
    output logic positive_input_select,
    output logic [1:0] negative_input_select,
    output logic comparator_out_pin,
    output logic comparator_out_pin_oe,
    output logic comparator_event,
    output logic irq
);
    // ============================================================
    // registers
    logic [7:0] control_r;
    logic [7:0] input_select_r;
    logic [7:0] irq_enable_r;
    logic flag_r;
    logic [2:0] sync_r;
    logic prev_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_held_r;
    logic w_held_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // ============================================================
    // sleep and enable decode
    wire logic in_standby = (sleep_mode == CMPC_SLEEP_STANDBY);
    wire logic in_power_down = (sleep_mode == CMPC_SLEEP_POWER_DOWN);
    wire logic run_in_standby = control_r[CMPC_BIT_RUN_IN_STANDBY];
    wire logic output_pad_enable = control_r[CMPC_BIT_OUTPUT_PAD_ENABLE];
    wire logic [1:0] irq_edge_select = control_r[CMPC_EDGE_HI:CMPC_EDGE_LO];
    wire logic invert = input_select_r[CMPC_BIT_INVERT];
    wire logic active = control_r[CMPC_BIT_ENABLE]
        & ~in_power_down
        & ~(in_standby & ~run_in_standby);
    // edge detect runs on aclk only outside standby and power-down; the synchronizer always runs
    wire logic status_live = ~in_standby & ~in_power_down;

    assign comparator_enable = active;
    assign hysteresis_select = control_r[CMPC_HYS_HI:CMPC_HYS_LO];
    assign positive_input_select = input_select_r[CMPC_BIT_POS];
    assign negative_input_select = input_select_r[CMPC_NEG_HI:CMPC_NEG_LO];

    // ============================================================
    // output path
    wire logic cmp_out = (comparator_raw ^ invert) & active;
    assign comparator_event = cmp_out;
    assign comparator_out_pin = cmp_out;
    assign comparator_out_pin_oe = output_pad_enable & active;

    // ============================================================
    // synchronizer and edge detect
    wire logic state_now = sync_r[2];
    wire logic rise = state_now & ~prev_r;
    wire logic fall = ~state_now & prev_r;
    wire logic edge_hit = status_live & (
        ((irq_edge_select == CMPC_ANY_EDGE_CODE) & (rise | fall)) |
        ((irq_edge_select == CMPC_FALL_EDGE_CODE) & fall) |
        ((irq_edge_select == CMPC_RISE_EDGE_CODE) & rise));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_r <= 3'h0;
            prev_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], cmp_out};
            if (status_live) begin
                prev_r <= state_now;
            end
        end
    end

    // ============================================================
    // axi4-lite write channel
    wire logic [CMPC_IDX_W-1:0] widx = awaddr_r[CMPC_ADDR_LSB +: CMPC_IDX_W];
    wire logic waddr_ok = (awaddr_r[31:CMPC_ADDR_LSB+CMPC_IDX_W] == '0) & (awaddr_r[1:0] == 2'h0);
    wire logic wr_go = aw_held_r & w_held_r & ~bvalid_r;
    wire logic wr_lane = wstrb_r[0];
    wire logic wr_ctrl = wr_go & waddr_ok & wr_lane & (widx == CMPC_IDX_CONTROL);
    wire logic wr_isel = wr_go & waddr_ok & wr_lane & (widx == CMPC_IDX_INPUT_SELECT);
    wire logic wr_ien = wr_go & waddr_ok & wr_lane & (widx == CMPC_IDX_IRQ_ENABLE);
    wire logic wr_stat = wr_go & waddr_ok & wr_lane & (widx == CMPC_IDX_STATUS);
    wire logic wr_hit = waddr_ok & ((widx == CMPC_IDX_CONTROL) | (widx == CMPC_IDX_INPUT_SELECT) |
        (widx == CMPC_IDX_IRQ_ENABLE) | (widx == CMPC_IDX_STATUS));
    wire logic flag_clear = wr_stat & wdata_r[CMPC_BIT_IRQ];

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= CMPC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? CMPC_RESP_OKAY : CMPC_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ============================================================
    // control registers and interrupt flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control_r <= CMPC_CONTROL_RST;
            input_select_r <= CMPC_INPUT_SELECT_RST;
            irq_enable_r <= CMPC_IRQ_ENABLE_RST;
            flag_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                control_r <= wdata_r[7:0];
            end
            if (wr_isel) begin
                input_select_r <= wdata_r[7:0];
            end
            if (wr_ien) begin
                irq_enable_r <= wdata_r[7:0];
            end
            if (edge_hit) begin
                flag_r <= 1'b1;
            end else if (flag_clear) begin
                flag_r <= 1'b0;
            end
        end
    end

    assign irq = flag_r & irq_enable_r[CMPC_BIT_IRQ];

    // ============================================================
    // axi4-lite read channel
    wire logic [CMPC_IDX_W-1:0] ridx = s_axi_araddr[CMPC_ADDR_LSB +: CMPC_IDX_W];
    wire logic raddr_ok = (s_axi_araddr[31:CMPC_ADDR_LSB+CMPC_IDX_W] == '0) & (s_axi_araddr[1:0] == 2'h0);
    wire logic [7:0] status_view = 8'h00 | (8'(state_now) << CMPC_BIT_STATE) | 8'(flag_r);
    wire logic [7:0] rd_byte =
        (ridx == CMPC_IDX_CONTROL) ? control_r :
        (ridx == CMPC_IDX_INPUT_SELECT) ? input_select_r :
        (ridx == CMPC_IDX_IRQ_ENABLE) ? irq_enable_r :
        (ridx == CMPC_IDX_STATUS) ? status_view : 8'h00;
    wire logic rd_hit = raddr_ok & ((ridx == CMPC_IDX_CONTROL) | (ridx == CMPC_IDX_INPUT_SELECT) |
        (ridx == CMPC_IDX_IRQ_ENABLE) | (ridx == CMPC_IDX_STATUS));

    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= CMPC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h0, rd_hit ? rd_byte : 8'h00};
            rresp_r <= rd_hit ? CMPC_RESP_OKAY : CMPC_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : cmpc_top
`default_nettype wire

/* File: test/cmpc_chk_props.sv */
// checker: port-level behaviour of the comparator control block
// assumes: bound into cmpc_top, one clock domain aclk
`default_nettype none
module cmpc_chk
    import cmpc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire cmpc_sleep_t sleep_mode,
    input wire logic comparator_enable,
    input wire logic [1:0] hysteresis_select,
    input wire logic [1:0] negative_input_select,
    input wire logic comparator_out_pin,
    input wire logic comparator_out_pin_oe,
    input wire logic comparator_event,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // assertions
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_pad; comparator_out_pin_oe |-> comparator_enable; endproperty
    a_pad: assert property (p_pad) else $error("pad driven while core off");
    property p_pd; sleep_mode == CMPC_SLEEP_POWER_DOWN |-> !comparator_enable && !comparator_out_pin_oe; endproperty
    a_pd: assert property (p_pd) else $error("core or pad on in power-down");
    property p_evt; comparator_event == comparator_out_pin; endproperty
    a_evt: assert property (p_evt) else $error("event differs from output");
    property p_off; !comparator_enable |-> !comparator_out_pin; endproperty
    a_off: assert property (p_off) else $error("output high while core off");
    property p_hold; irq |=> irq || $rose(s_axi_bvalid); endproperty
    a_hold: assert property (p_hold) else $error("irq dropped without a write");
    property p_stby; sleep_mode == CMPC_SLEEP_STANDBY ##1 $rose(irq) |-> $rose(s_axi_bvalid); endproperty
    a_stby: assert property (p_stby) else $error("irq raised in standby");
    property p_hys; $changed(hysteresis_select) |-> $rose(s_axi_bvalid); endproperty
    a_hys: assert property (p_hys) else $error("hysteresis changed without a write");
    property p_mux; $changed(negative_input_select) |-> $rose(s_axi_bvalid); endproperty
    a_mux: assert property (p_mux) else $error("input select changed without a write");
endmodule : cmpc_chk
bind cmpc_top cmpc_chk cmpc_chk_inst (.aclk, .aresetn, .s_axi_bvalid, .sleep_mode, .comparator_enable,
    .hysteresis_select, .negative_input_select, .comparator_out_pin, .comparator_out_pin_oe,
    .comparator_event, .irq);
`default_nettype wire

/* File: test/cmpc_core_model.sv */
// analog comparator core model: output high when the positive input wins
// assumes: bench sets the input difference sign; core output low while switched off
`default_nettype none
module cmpc_core_model #(
    parameter int unsigned DLY_NS = 7
) (
    input wire logic enable,
    input wire logic diff_positive,
    output logic raw
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // delayed, clock-independent core output
    assign #(DLY_NS) raw = enable & diff_positive;
endmodule : cmpc_core_model
`default_nettype wire

/* File: test/tb.sv */
// testbench: register access, state sync, edge flags, sleep gating
// assumes: checker bound to cmpc_top, core model drives comparator_raw
`default_nettype none
module tb;
    import cmpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, positive_input_select, comparator_raw;
    logic comparator_enable, comparator_out_pin, comparator_out_pin_oe, comparator_event, irq, lvl;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, hysteresis_select, negative_input_select;
    logic [3:0] rise_tbl = 4'b1001;
    logic [3:0] fall_tbl = 4'b0101;
    cmpc_sleep_t sleep_mode;
    int err_count, tests_run, cyc;
    cmpc_top cmpc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sleep_mode, .comparator_raw, .comparator_enable, .hysteresis_select,
        .positive_input_select, .negative_input_select, .comparator_out_pin, .comparator_out_pin_oe,
        .comparator_event, .irq);
    cmpc_core_model cmpc_core_model_inst (.enable(comparator_enable), .diff_positive(lvl), .raw(comparator_raw));
    // ==========
    // clock, timeout, tasks
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            err_count++;
        end
    endtask : chk
    task automatic wr(input logic [2:0] i, input logic [7:0] d, input logic [1:0] er = CMPC_RESP_OKAY);
        logic ah = 1'b0;
        logic wh = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {27'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ah && wh)) begin
            @(posedge aclk);
            ah = ah | s_axi_awready;
            wh = wh | s_axi_wready;
            s_axi_awvalid <= !ah;
            s_axi_wvalid <= !wh;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [2:0] i, input logic [7:0] e, input logic [1:0] er = CMPC_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= {27'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask : rd
    // ==========
    // main sequence
    initial begin
        aresetn = 1'b0;
        sleep_mode = CMPC_SLEEP_ACTIVE;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, lvl} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rd(k[2:0], 8'h00, (k inside {0, 2, 6, 7}) ? CMPC_RESP_OKAY : CMPC_RESP_SLVERR);
        end
        wr(3'h1, 8'hff, CMPC_RESP_SLVERR);
        for (int k = 0; k < 4; k++) begin
            wr(CMPC_IDX_CONTROL, {2'h1, 3'h0, k[1:0], 1'b1});
            chk("hys", k, hysteresis_select);
        end
        chk("oe", 1, comparator_out_pin_oe);
        rd(CMPC_IDX_CONTROL, 8'h47);
        wr(CMPC_IDX_INPUT_SELECT, 8'h02);
        chk("neg", CMPC_NEG_VREF, negative_input_select);
        chk("pos", CMPC_POS_PIN_ZERO, positive_input_select);
        wr(CMPC_IDX_IRQ_ENABLE, 8'h01);
        lvl <= 1'b1;
        rd(CMPC_IDX_STATUS, 8'h00);
        rd(CMPC_IDX_STATUS, 8'h11);
        chk("irq", 1, irq);
        wr(CMPC_IDX_STATUS, 8'h10);
        rd(CMPC_IDX_STATUS, 8'h11);
        wr(CMPC_IDX_STATUS, 8'h01);
        chk("irq", 0, irq);
        for (int k = 0; k < 4; k++) begin
            wr(CMPC_IDX_CONTROL, {2'h0, k[1:0], 4'h1});
            lvl <= 1'b0;
            repeat (5) @(posedge aclk);
            rd(CMPC_IDX_STATUS, {7'h0, fall_tbl[k]});
            wr(CMPC_IDX_STATUS, 8'h01);
            lvl <= 1'b1;
            repeat (5) @(posedge aclk);
            rd(CMPC_IDX_STATUS, {4'h1, 3'h0, rise_tbl[k]});
            wr(CMPC_IDX_STATUS, 8'h01);
        end
        wr(CMPC_IDX_CONTROL, 8'h41);
        wr(CMPC_IDX_INPUT_SELECT, 8'h80);
        repeat (5) @(posedge aclk);
        rd(CMPC_IDX_STATUS, 8'h01);
        chk("pin", 0, comparator_out_pin);
        chk("event", 0, comparator_event);
        wr(CMPC_IDX_STATUS, 8'h01);
        sleep_mode <= CMPC_SLEEP_STANDBY;
        @(posedge aclk);
        chk("en", 0, comparator_enable);
        sleep_mode <= CMPC_SLEEP_ACTIVE;
        wr(CMPC_IDX_CONTROL, 8'hc1);
        sleep_mode <= CMPC_SLEEP_STANDBY;
        lvl <= 1'b0;
        repeat (5) @(posedge aclk);
        chk("pin", 1, comparator_out_pin);
        chk("event", 1, comparator_event);
        chk("irq", 0, irq);
        lvl <= 1'b1;
        repeat (5) @(posedge aclk);
        sleep_mode <= CMPC_SLEEP_ACTIVE;
        rd(CMPC_IDX_STATUS, 8'h00);
        sleep_mode <= CMPC_SLEEP_POWER_DOWN;
        @(posedge aclk);
        chk("en", 0, comparator_enable);
        chk("oe", 0, comparator_out_pin_oe);
        close_out();
    end
endmodule : tb
`default_nettype wire
